// File: dv/citd_mem_model.sv
// Behavioural program memory and data space that face the decode core.
// Assumes the core presents addresses after rising edges; reads are combinational.
`timescale 1ns/100ps
module citd_mem_model (
	input wire logic clock, // Instruction clock
	input wire logic [22:0] pc, // Fetch address
	output logic [23:0] instr, // Fetched word
	input wire logic [15:0] data_addr, // Data address
	output logic [15:0] data_rdata, // Data read value
	input wire logic [15:0] data_wdata, // Data write value
	input wire logic data_we, // Data write strobe
	input wire logic [22:0] tbl_addr, // Table address
	output logic [23:0] tbl_rdata // Table word
);
	logic [23:0] pm [0:255];
	logic [15:0] dm [0:255];
	initial begin
		for (int i = 0; i < 256; i++) begin
			pm[i] = 24'h000000;
			dm[i] = 16'h0000;
		end
	end
	// Whole 24-bit words, low address bits only
	assign instr = pm[pc[7:0]];
	assign tbl_rdata = pm[tbl_addr[7:0]];
	assign data_rdata = dm[data_addr[7:0]];
	always @(posedge clock) begin
		if (data_we === 1'b1) begin
			dm[data_addr[7:0]] <= data_wdata;
		end
	end
endmodule

// File: dv/tb_top.sv
// Self-checking bench for the decode and timing core.
// Assumes the core's opcode and field layout from the shared package.
`timescale 1ns/100ps
module tb_top;
	localparam logic [23:0] FILL = {citd_pkg::OP_MOV_LIT8, 18'h00003};
	logic clock, sys_rst, data_in_psv, exc_pending;
	logic [22:0] pc, tbl_addr;
	logic [23:0] instr, tbl_rdata, tbl_wdata;
	logic [15:0] data_addr, data_rdata, data_wdata, div_dividend, div_divisor;
	logic data_we, div_step, nop_cycle, illegal;
	logic [1:0] tbl_we, div_kind;
	int n_fail, n_checks;
	////////////////////////////////////////////////////////////////
	citd_core dut (.clock(clock), .sys_rst(sys_rst), .pc(pc), .instr(instr), .data_addr(data_addr),
		.data_rdata(data_rdata), .data_wdata(data_wdata), .data_we(data_we), .data_in_psv(data_in_psv),
		.tbl_addr(tbl_addr), .tbl_rdata(tbl_rdata), .tbl_wdata(tbl_wdata), .tbl_we(tbl_we),
		.exc_pending(exc_pending), .div_dividend(div_dividend), .div_divisor(div_divisor),
		.div_kind(div_kind), .div_step(div_step), .nop_cycle(nop_cycle), .illegal(illegal));
	citd_mem_model mem (.clock(clock), .pc(pc), .instr(instr), .data_addr(data_addr),
		.data_rdata(data_rdata), .data_wdata(data_wdata), .data_we(data_we), .tbl_addr(tbl_addr),
		.tbl_rdata(tbl_rdata));
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// Fill memories, place three words at 0..2, then restart the core
	task automatic load(input logic [23:0] w0, input logic [23:0] w1, input logic [23:0] w2);
		for (int i = 0; i < 256; i++) begin
			mem.pm[i] = FILL;
			mem.dm[i] = 16'h3C96;
		end
		mem.pm[0] = w0;
		mem.pm[1] = w1;
		mem.pm[2] = w2;
		@(negedge clock);
		sys_rst = 1'b1;
		repeat (2) @(negedge clock);
		sys_rst = 1'b0;
	endtask
	task automatic wait_pc(input logic [22:0] a);
		for (int i = 0; i < 8 && !(pc === a && nop_cycle === 1'b0); i++) begin
			@(negedge clock);
		end
	endtask
	function automatic logic [23:0] lit8(input logic [3:0] wd, input logic [7:0] v);
		return {citd_pkg::OP_MOV_LIT8, 6'h00, v, wd};
	endfunction
	function automatic logic [23:0] div(input logic [5:0] op, input logic [3:0] wm, input logic [3:0] wn);
		return {op, 6'h00, wn, wm, 4'h0};
	endfunction
	////////////////////////////////////////////////////////////////
	task automatic t_lit_div();
		load(lit8(4'h1, 8'hAB), lit8(4'h2, 8'h5C), div(citd_pkg::OP_DIV_UNS, 4'h1, 4'h2));
		mem.pm[3] = div(citd_pkg::OP_DIV_FRAC, 4'h1, 4'h2);
		mem.pm[4] = div(citd_pkg::OP_DIV_SGN, 4'h2, 4'h1);
		repeat (2) @(negedge clock);
		chk("pc", pc, 23'h000002);
		chk("dividend", div_dividend, 16'h00AB);
		chk("divisor", div_divisor, 16'h005C);
		chk("div kind unsigned", div_kind, 2'h2);
		chk("div step", div_step, 1'b1);
		@(negedge clock);
		chk("div kind fractional", div_kind, 2'h0);
		@(negedge clock);
		chk("div kind signed", div_kind, 2'h1);
		chk("swapped dividend", div_dividend, 16'h005C);
	endtask
	task automatic t_time(input logic [23:0] w0, input logic [23:0] w1, input logic exc, input logic psv,
		input int hold, input int nops);
		logic hs [0:6];
		logic ns [0:6];
		int h;
		int n;
		exc_pending = exc;
		data_in_psv = psv;
		load(w0, w1, FILL);
		for (int i = 0; i < 7; i++) begin
			hs[i] = (pc === 23'h0);
			ns[i] = (nop_cycle === 1'b1);
			@(negedge clock);
		end
		h = 0;
		while (h < 7 && hs[h]) h++;
		n = 1;
		while (n < 7 && ns[n]) n++;
		chk("no-op cycles", n - 1, nops);
		if (hold > 0) begin
			chk("instruction cycles", h + n - 1, hold);
		end
		exc_pending = 1'b0;
		data_in_psv = 1'b0;
	endtask
	task automatic t_timing();
		logic [5:0] ops [0:5];
		logic [5:0] rets [0:2];
		logic [23:0] jmp;
		ops = '{citd_pkg::OP_TBL_READ, citd_pkg::OP_TBL_WRITE, citd_pkg::OP_PUSHD, citd_pkg::OP_POPD,
			citd_pkg::OP_MOVD_TO_PAIR, citd_pkg::OP_MOVD_FROM_PAIR};
		rets = '{citd_pkg::OP_RETURN, citd_pkg::OP_RET_LIT, citd_pkg::OP_RET_INT};
		jmp = {citd_pkg::OP_JUMP, 18'h00040};
		foreach (ops[i]) t_time({ops[i], 18'h0}, FILL, 1'b0, 1'b0, 2, 1);
		foreach (rets[i]) begin
			t_time({rets[i], 18'h0}, FILL, 1'b0, 1'b0, 0, 2);
			t_time({rets[i], 18'h0}, FILL, 1'b1, 1'b0, 0, 1);
		end
		t_time({citd_pkg::OP_BRANCH, 18'h0}, FILL, 1'b0, 1'b0, 0, 1);
		t_time(jmp, 24'h000000, 1'b0, 1'b0, 0, 1);
		t_time({citd_pkg::OP_SKIP_CLR, 18'h0}, FILL, 1'b0, 1'b0, 0, 1);
		t_time({citd_pkg::OP_SKIP_CLR, 18'h0}, jmp, 1'b0, 1'b0, 0, 2);
		t_time({citd_pkg::OP_MOV_F_TO_W, 18'h0}, FILL, 1'b0, 1'b0, 1, 0);
		t_time({citd_pkg::OP_MOV_F_TO_W, 18'h0}, FILL, 1'b0, 1'b1, 2, 1);
	endtask
	task automatic t_flow();
		load({citd_pkg::OP_SKIP_CLR, 18'h0}, {citd_pkg::OP_JUMP, 18'h00040}, 24'h000000);
		wait_pc(23'h000003);
		chk("pc after skip", pc, 23'h000003);
		load({citd_pkg::OP_JUMP, 18'h00040}, 24'h000000, FILL);
		wait_pc(23'h000040);
		chk("jump target", pc, 23'h000040);
		load({citd_pkg::OP_CALL, 18'h00020}, 24'h000001, FILL);
		wait_pc(23'h010020);
		chk("call target", pc, 23'h010020);
	endtask
	task automatic t_table();
		logic [23:0] w;
		logic [1:0] seen;
		for (int u = 0; u < 2; u++) begin
			w = {citd_pkg::OP_TBL_READ, 1'b0, u[0], 8'h00, 4'h0, 4'h5};
			load(w, FILL, div(citd_pkg::OP_DIV_UNS, 4'h5, 4'h1));
			wait_pc(23'h000002);
			chk("table read", div_dividend, (u == 1) ? {8'h00, w[23:16]} : w[15:0]);
			load({citd_pkg::OP_TBL_WRITE, 1'b0, u[0], 16'h0000}, FILL, FILL);
			seen = 2'b00;
			for (int i = 0; i < 3; i++) begin
				seen = seen | tbl_we;
				@(negedge clock);
			end
			chk("table write lane", seen, (u == 1) ? 2'b10 : 2'b01);
		end
	endtask
	task automatic t_default_reg();
		load({citd_pkg::OP_MOV_FILE, 1'b1, 13'h0010, 4'h0}, div(citd_pkg::OP_DIV_UNS, 4'h0, 4'h1), FILL);
		@(negedge clock);
		chk("default reg dest", div_dividend, 16'h3C96);
		load({citd_pkg::OP_MOV_FILE, 1'b0, 13'h0010, 4'h0}, div(citd_pkg::OP_DIV_UNS, 4'h0, 4'h1), FILL);
		chk("file write strobe", data_we, 1'b1);
		chk("file write value", data_wdata, 16'h3C96);
		@(negedge clock);
		chk("default reg kept", div_dividend, 16'h0000);
	endtask
	task automatic t_repeat();
		int n;
		n = 0;
		load({citd_pkg::OP_REPEAT, 18'h0}, div(citd_pkg::OP_DIV_UNS, 4'h1, 4'h2), FILL);
		for (int i = 0; i < 26; i++) begin
			n = n + ((div_step === 1'b1) ? 1 : 0);
			@(negedge clock);
		end
		chk("repeated divide steps", n, 18);
	endtask
	// Word literal, in-place exchange, and indexed load with a negative offset
	task automatic t_moves();
		load({citd_pkg::OP_MOV_LIT16, 2'b00, 16'h1231}, {citd_pkg::OP_REGISTER_EXCHANGE, 2'b00, 12'h000, 4'h1},
			div(citd_pkg::OP_DIV_UNS, 4'h1, 4'h2));
		repeat (2) @(negedge clock);
		chk("word literal exchanged", div_dividend, 16'h3112);
		load({citd_pkg::OP_MOV_LIT16, 2'b00, 16'h0102}, {citd_pkg::OP_LOAD_IDX, 4'h0, 10'h3F2, 4'h3},
			div(citd_pkg::OP_DIV_UNS, 4'h3, 4'h2));
		mem.dm[8'hF4] = 16'h5A5A;
		@(negedge clock);
		chk("indexed load address", data_addr, 16'h00F4);
		@(negedge clock);
		chk("indexed load value", div_dividend, 16'h5A5A);
		chk("word literal value", div_divisor, 16'h0102);
	endtask
	task automatic t_illegal();
		load(24'hFC0000, FILL, FILL);
		chk("illegal pulse", illegal, 1'b1);
		@(negedge clock);
		chk("pc after illegal", pc, 23'h000001);
		chk("illegal cleared", illegal, 1'b0);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		n_fail = 0;
		n_checks = 0;
		sys_rst = 1'b1;
		data_in_psv = 1'b0;
		exc_pending = 1'b0;
		repeat (20) @(negedge clock);
		sys_rst = 1'b0;
		chk("pc after reset", pc, 23'h000000);
		t_lit_div();
		t_timing();
		t_flow();
		t_table();
		t_default_reg();
		t_repeat();
		t_moves();
		t_illegal();
		end_of_test();
	end
	// Whole run is well under 2000 cycles
	initial begin
		#(50 * 6000);
		n_fail++;
		end_of_test();
	end
endmodule

// File: shared/citd_pkg.sv
// Constants and types for the instruction decode and timing block.
// Assumes a single 20 MHz instruction clock; no software-visible registers.
package citd_pkg;
	localparam int INSTR_W = 24;
	localparam int DATA_W = 16;
	localparam int FILE_ADDR_W = 13;
	localparam int PC_W = 23;
	// Opcode in bits 23:18; fields below
	localparam int OPC_HI = 23;
	localparam int OPC_LO = 18;
	localparam int WD_LO = 0;
	localparam int WS_LO = 4;
	localparam int LIT16_LO = 0;
	localparam int UNSIGNED_TEN_BIT_LITERAL_LO = 4;
	localparam int LIT8_LO = 4;
	localparam int BIT_POSITION_FIELD_LO = 12;
	localparam int FILE_LO = 4;
	localparam int DEF_BIT = 17;
	localparam int BYTE_BIT = 16;
	localparam int UPPER_BIT = 16;
	localparam int DIV_DIVISOR_LO = 8;
	localparam logic [5:0] OP_NOP = 6'h00;
	localparam logic [5:0] OP_MOV_FILE = 6'h01;
	localparam logic [5:0] OP_MOV_DEF_TO_F = 6'h02;
	localparam logic [5:0] OP_MOV_F_TO_W = 6'h03;
	localparam logic [5:0] OP_MOV_W_TO_F = 6'h04;
	localparam logic [5:0] OP_MOV_LIT8 = 6'h05;
	localparam logic [5:0] OP_MOV_LIT16 = 6'h06;
	localparam logic [5:0] OP_LOAD_IDX = 6'h07;
	localparam logic [5:0] OP_STORE_IDX = 6'h08;
	localparam logic [5:0] OP_MOV_WW = 6'h09;
	localparam logic [5:0] OP_MOVD_TO_PAIR = 6'h0A;
	localparam logic [5:0] OP_MOVD_FROM_PAIR = 6'h0B;
	localparam logic [5:0] OP_REGISTER_EXCHANGE = 6'h0C;
	localparam logic [5:0] OP_SWAP = 6'h0D;
	localparam logic [5:0] OP_TBL_READ = 6'h0E;
	localparam logic [5:0] OP_TBL_WRITE = 6'h0F;
	localparam logic [5:0] OP_PUSHD = 6'h10;
	localparam logic [5:0] OP_POPD = 6'h11;
	localparam logic [5:0] OP_DIV_FRAC = 6'h12;
	localparam logic [5:0] OP_DIV_SGN = 6'h13;
	localparam logic [5:0] OP_DIV_UNS = 6'h14;
	localparam logic [5:0] OP_ADD_F = 6'h15;
	localparam logic [5:0] OP_ADD_UNSIGNED_TEN_BIT_LITERAL = 6'h16;
	localparam logic [5:0] OP_BRANCH = 6'h17;
	localparam logic [5:0] OP_JUMP = 6'h18;
	localparam logic [5:0] OP_CALL = 6'h19;
	localparam logic [5:0] OP_RETURN = 6'h1A;
	localparam logic [5:0] OP_RET_LIT = 6'h1B;
	localparam logic [5:0] OP_RET_INT = 6'h1C;
	localparam logic [5:0] OP_SKIP_CLR = 6'h1D;
	localparam logic [5:0] OP_REPEAT = 6'h1E;
	localparam logic [3:0] DEFAULT_REG = 4'h0;
	localparam logic [4:0] DIV_REPEAT_CNT = 5'h12;
	localparam logic [1:0] CYC_MULTI = 2'h2;
	localparam logic [1:0] CYC_FLOW = 2'h2;
	localparam logic [1:0] CYC_SKIP2 = 2'h3;
	localparam logic [1:0] CYC_RET = 2'h3;
	localparam logic [1:0] CYC_RET_EXC = 2'h2;
	localparam logic [1:0] PSV_EXTRA = 2'h1;
	typedef enum {CITD_FETCH, CITD_SECOND, CITD_STALL} citd_state_t;
endpackage

// File: shared/citd_rf_if.sv
// Register file port bundle between the decoder and the register bank.
// Assumes one write port per cycle plus a paired-register write.
`timescale 1ns/100ps
interface citd_rf_if;
	logic [3:0] ra;
	logic [3:0] rb;
	logic [15:0] da;
	logic [15:0] db;
	logic we;
	logic [3:0] wa;
	logic [15:0] wd;
	logic we2;
	logic [15:0] wd2;
	modport core (output ra, output rb, input da, input db, output we, output wa, output wd, output we2, output wd2);
	modport bank (input ra, input rb, output da, output db, input we, input wa, input wd, input we2, input wd2);
endinterface

// File: verilog/citd_core.sv
// Decode and timing for the move, divide, table and flow instruction subset.
// Assumes single-cycle program word fetch and a combinational data space read.
`timescale 1ns/100ps
module citd_core (
	input wire logic clock, // 20 MHz instruction clock
	input wire logic sys_rst, // Sync reset, active high
	output logic [22:0] pc, // Program word address
	input wire logic [23:0] instr, // Fetched word
	output logic [15:0] data_addr, // Data space address
	input wire logic [15:0] data_rdata, // Data read value
	output logic [15:0] data_wdata, // Data write value
	output logic data_we, // Data write strobe
	input wire logic data_in_psv, // Access hits program window
	output logic [22:0] tbl_addr, // Table access address
	input wire logic [23:0] tbl_rdata, // Table read word
	output logic [23:0] tbl_wdata, // Table write word
	output logic [1:0] tbl_we, // Table lane write: 1 upper, 0 lower
	input wire logic exc_pending, // Exception pending
	output logic [15:0] div_dividend, // Divide dividend
	output logic [15:0] div_divisor, // Divide divisor
	output logic [1:0] div_kind, // 0 frac 1 signed 2 unsigned
	output logic div_step, // One divide step pulse
	output logic nop_cycle, // Cycle executed as no-operation
	output logic illegal // Unknown opcode pulse
);
	citd_rf_if rf();
	citd_regbank u_bank (.clock(clock), .sys_rst(sys_rst), .rf(rf));
	citd_pkg::citd_state_t state_r;
	logic [22:0] pc_r;
	logic [23:0] ir_r;
	logic [4:0] rpt_r;
	logic load;
	logic [2:0] cycles;
	logic busy;
	logic skip_two_r;
	citd_cycle_cnt u_cnt (.clock(clock), .sys_rst(sys_rst), .load(load), .cycles(cycles), .busy(busy));
	////////////////////////////////////////////////////////////////
	// Field extraction
	logic [5:0] opc;
	logic [3:0] wd;
	logic [3:0] ws;
	logic [3:0] bitpos;
	logic [9:0] unsigned_ten_bit_literal;
	logic [15:0] off16;
	logic [15:0] lit16;
	logic [7:0] lit8;
	logic [12:0] faddr;
	logic use_def;
	logic byte_mode;
	logic exec;
	assign exec = (state_r == citd_pkg::CITD_FETCH) && !busy;
	assign opc = instr[citd_pkg::OPC_HI:citd_pkg::OPC_LO];
	assign wd = instr[citd_pkg::WD_LO +: 4];
	assign ws = instr[citd_pkg::WS_LO +: 4];
	assign bitpos = instr[citd_pkg::BIT_POSITION_FIELD_LO +: 4];
	assign unsigned_ten_bit_literal = instr[citd_pkg::UNSIGNED_TEN_BIT_LITERAL_LO +: 10];
	assign off16 = {{6{unsigned_ten_bit_literal[9]}}, unsigned_ten_bit_literal};
	assign lit16 = instr[citd_pkg::LIT16_LO +: 16];
	assign lit8 = instr[citd_pkg::LIT8_LO +: 8];
	assign faddr = instr[citd_pkg::FILE_LO +: 13];
	assign use_def = instr[citd_pkg::DEF_BIT];
	assign byte_mode = instr[citd_pkg::BYTE_BIT];
	logic [15:0] unsigned_ten_bit_literal_val;
	// Byte mode keeps the low eight bits only
	assign unsigned_ten_bit_literal_val = byte_mode ? {8'h00, unsigned_ten_bit_literal[7:0]} : {6'h00, unsigned_ten_bit_literal};
	////////////////////////////////////////////////////////////////
	// Register and data port steering
	logic [15:0] sum_idx;
	logic [15:0] swapped;
	always_comb begin
		rf.ra = ws;
		rf.rb = wd;
		if (opc == citd_pkg::OP_MOV_F_TO_W || opc == citd_pkg::OP_MOV_DEF_TO_F) rf.ra = citd_pkg::DEFAULT_REG;
		if (opc == citd_pkg::OP_MOV_W_TO_F) rf.ra = wd;
		if (opc == citd_pkg::OP_MOVD_FROM_PAIR || opc == citd_pkg::OP_PUSHD) rf.rb = 4'(ws + 4'h1);
		if (opc == citd_pkg::OP_DIV_FRAC || opc == citd_pkg::OP_DIV_SGN || opc == citd_pkg::OP_DIV_UNS) begin
			rf.ra = ws;
			rf.rb = instr[citd_pkg::DIV_DIVISOR_LO +: 4];
		end
	end
	assign sum_idx = (opc == citd_pkg::OP_STORE_IDX) ? 16'(rf.db + off16) : 16'(rf.da + off16);
	assign swapped = byte_mode ? {rf.db[15:8], rf.db[3:0], rf.db[7:4]} : {rf.db[7:0], rf.db[15:8]};
	always_comb begin
		data_addr = 16'h0000;
		data_wdata = 16'h0000;
		data_we = 1'b0;
		if (exec) begin
			unique case (opc)
				citd_pkg::OP_MOV_F_TO_W, citd_pkg::OP_ADD_F: data_addr = {3'h0, faddr};
				citd_pkg::OP_MOV_FILE: begin
					// Without the default-register option the value goes back to the file register
					data_addr = {3'h0, faddr};
					data_wdata = data_rdata;
					data_we = !use_def;
				end
				citd_pkg::OP_MOV_DEF_TO_F, citd_pkg::OP_MOV_W_TO_F: begin
					data_addr = {3'h0, faddr};
					data_wdata = rf.da;
					data_we = 1'b1;
				end
				citd_pkg::OP_LOAD_IDX: data_addr = sum_idx;
				citd_pkg::OP_STORE_IDX: begin
					data_addr = sum_idx;
					data_wdata = rf.da;
					data_we = 1'b1;
				end
				default: data_addr = 16'h0000;
			endcase
		end
	end
	////////////////////////////////////////////////////////////////
	// Register write-back
	always_comb begin
		rf.we = 1'b0;
		rf.wa = wd;
		rf.wd = 16'h0000;
		rf.we2 = 1'b0;
		rf.wd2 = 16'h0000;
		if (exec) begin
			unique case (opc)
				citd_pkg::OP_MOV_FILE: begin
					rf.we = use_def;
					rf.wa = citd_pkg::DEFAULT_REG;
					rf.wd = data_rdata;
				end
				citd_pkg::OP_ADD_F: begin
					rf.we = use_def;
					rf.wa = citd_pkg::DEFAULT_REG;
					rf.wd = 16'(data_rdata + rf.da);
				end
				citd_pkg::OP_ADD_UNSIGNED_TEN_BIT_LITERAL: begin
					rf.we = 1'b1;
					rf.wd = 16'(rf.db + unsigned_ten_bit_literal_val);
				end
				citd_pkg::OP_MOV_F_TO_W, citd_pkg::OP_LOAD_IDX: begin
					rf.we = 1'b1;
					rf.wd = data_rdata;
				end
				citd_pkg::OP_MOV_LIT8: begin
					rf.we = 1'b1;
					rf.wd = {rf.db[15:8], lit8};
				end
				citd_pkg::OP_MOV_LIT16: begin
					rf.we = 1'b1;
					rf.wd = lit16;
				end
				citd_pkg::OP_MOV_WW: begin
					rf.we = 1'b1;
					rf.wd = rf.da;
				end
				citd_pkg::OP_MOVD_TO_PAIR, citd_pkg::OP_POPD: begin
					rf.we = 1'b1;
					rf.wd = rf.da;
					rf.we2 = 1'b1;
					rf.wd2 = data_rdata;
				end
				citd_pkg::OP_REGISTER_EXCHANGE, citd_pkg::OP_SWAP: begin
					rf.we = 1'b1;
					rf.wd = swapped;
				end
				citd_pkg::OP_TBL_READ: begin
					rf.we = 1'b1;
					rf.wd = instr[citd_pkg::UPPER_BIT] ? {8'h00, tbl_rdata[23:16]} : tbl_rdata[15:0];
				end
				default: rf.we = 1'b0;
			endcase
		end
	end
	assign tbl_addr = {7'h00, rf.da};
	assign tbl_wdata = instr[citd_pkg::UPPER_BIT] ? {rf.da[7:0], 16'h0000} : {8'h00, rf.da};
	assign tbl_we = (exec && opc == citd_pkg::OP_TBL_WRITE) ? (instr[citd_pkg::UPPER_BIT] ? 2'h2 : 2'h1) : 2'h0;
	assign div_dividend = rf.da;
	assign div_divisor = rf.db;
	assign div_kind = (opc == citd_pkg::OP_DIV_FRAC) ? 2'h0 : (opc == citd_pkg::OP_DIV_SGN) ? 2'h1 : 2'h2;
	assign div_step = exec && (opc == citd_pkg::OP_DIV_FRAC || opc == citd_pkg::OP_DIV_SGN || opc == citd_pkg::OP_DIV_UNS);
	////////////////////////////////////////////////////////////////
	// Cycle timing
	logic is_two_word;
	logic known;
	always_comb begin
		cycles = 3'h1;
		known = 1'b1;
		unique case (opc)
			citd_pkg::OP_MOVD_TO_PAIR, citd_pkg::OP_MOVD_FROM_PAIR, citd_pkg::OP_PUSHD, citd_pkg::OP_POPD,
			citd_pkg::OP_TBL_READ, citd_pkg::OP_TBL_WRITE: cycles = {1'b0, citd_pkg::CYC_MULTI};
			citd_pkg::OP_BRANCH: cycles = {1'b0, citd_pkg::CYC_FLOW};
			citd_pkg::OP_RETURN, citd_pkg::OP_RET_LIT, citd_pkg::OP_RET_INT:
				cycles = {1'b0, exc_pending ? citd_pkg::CYC_RET_EXC : citd_pkg::CYC_RET};
			citd_pkg::OP_NOP, citd_pkg::OP_MOV_FILE, citd_pkg::OP_MOV_DEF_TO_F, citd_pkg::OP_MOV_F_TO_W,
			citd_pkg::OP_MOV_W_TO_F, citd_pkg::OP_MOV_LIT8, citd_pkg::OP_MOV_LIT16, citd_pkg::OP_LOAD_IDX,
			citd_pkg::OP_STORE_IDX, citd_pkg::OP_MOV_WW, citd_pkg::OP_REGISTER_EXCHANGE, citd_pkg::OP_SWAP,
			citd_pkg::OP_DIV_FRAC, citd_pkg::OP_DIV_SGN, citd_pkg::OP_DIV_UNS, citd_pkg::OP_ADD_F,
			citd_pkg::OP_ADD_UNSIGNED_TEN_BIT_LITERAL, citd_pkg::OP_JUMP, citd_pkg::OP_CALL, citd_pkg::OP_SKIP_CLR,
			citd_pkg::OP_REPEAT: cycles = 3'h1;
			default: known = 1'b0;
		endcase
		// Program window data access adds one cycle to file moves, file-to-W moves and indexed loads
		if (data_in_psv && (opc == citd_pkg::OP_MOV_FILE || opc == citd_pkg::OP_LOAD_IDX ||
			opc == citd_pkg::OP_MOV_F_TO_W)) cycles = 3'(cycles + {1'b0, citd_pkg::PSV_EXTRA});
	end
	assign is_two_word = opc == citd_pkg::OP_JUMP || opc == citd_pkg::OP_CALL;
	assign load = exec && cycles != 3'h1;
	assign illegal = exec && !known;
	assign pc = pc_r;
	logic skip_taken;
	assign skip_taken = exec && opc == citd_pkg::OP_SKIP_CLR && !rf.da[bitpos];
	////////////////////////////////////////////////////////////////
	// Fetch sequencing
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			state_r <= citd_pkg::CITD_FETCH;
			pc_r <= 23'h000000;
			ir_r <= 24'h000000;
			skip_two_r <= 1'b0;
		end else begin
			unique case (state_r)
				citd_pkg::CITD_FETCH: begin
					if (busy) begin
						state_r <= citd_pkg::CITD_FETCH;
					end else if (is_two_word) begin
						ir_r <= instr;
						pc_r <= 23'(pc_r + 23'h1);
						state_r <= citd_pkg::CITD_SECOND;
					end else if (opc == citd_pkg::OP_BRANCH) begin
						pc_r <= 23'(pc_r + {{7{lit16[15]}}, lit16});
					end else if (skip_taken) begin
						pc_r <= 23'(pc_r + 23'h1);
						state_r <= citd_pkg::CITD_STALL;
					end else if (div_step && rpt_r > 5'h01) begin
						// Repeated divide re-executes the same word
						pc_r <= pc_r;
					end else begin
						pc_r <= 23'(pc_r + 23'h1);
					end
				end
				citd_pkg::CITD_SECOND: begin
					// Second word holds the high target bits; this cycle is the no-operation
					pc_r <= {instr[6:0], ir_r[15:0]};
					state_r <= citd_pkg::CITD_FETCH;
				end
				citd_pkg::CITD_STALL: begin
					// Skipped word: a two-word target costs one more no-operation
					if (is_two_word && !skip_two_r) begin
						skip_two_r <= 1'b1;
						pc_r <= 23'(pc_r + 23'h1);
					end else begin
						skip_two_r <= 1'b0;
						pc_r <= 23'(pc_r + 23'h1);
						state_r <= citd_pkg::CITD_FETCH;
					end
				end
			endcase
			if (state_r == citd_pkg::CITD_FETCH && skip_two_r) skip_two_r <= 1'b0;
		end
	end
	assign nop_cycle = busy || state_r != citd_pkg::CITD_FETCH || skip_two_r;
	////////////////////////////////////////////////////////////////
	// Repeat count seen by the divide
	always_ff @(posedge clock) begin
		if (sys_rst) rpt_r <= 5'h00;
		else if (exec && opc == citd_pkg::OP_REPEAT) rpt_r <= citd_pkg::DIV_REPEAT_CNT;
		else if (div_step && rpt_r != 5'h00) rpt_r <= 5'(rpt_r - 5'h01);
	end
	////////////////////////////////////////////////////////////////
	// Checks
	sequence s_ret_normal;
		exec && (opc == citd_pkg::OP_RETURN) && !exc_pending && !data_in_psv;
	endsequence
	AST_RET_CYC: assert property (@(posedge clock) disable iff (sys_rst) s_ret_normal |=> busy ##1 busy ##1 !busy)
		else $error("return did not take three cycles");
	AST_MULTI_CYC: assert property (@(posedge clock) disable iff (sys_rst)
		(exec && opc == citd_pkg::OP_TBL_READ && !data_in_psv) |=> busy ##1 !busy)
		else $error("table read not two cycles");
	AST_BRANCH_NOP: assert property (@(posedge clock) disable iff (sys_rst)
		(exec && opc == citd_pkg::OP_BRANCH) |=> nop_cycle)
		else $error("branch missing no-operation cycle");
	AST_LIT16: assert property (@(posedge clock) disable iff (sys_rst)
		(exec && opc == citd_pkg::OP_MOV_LIT16) |-> rf.we && rf.wd == lit16)
		else $error("word literal not loaded");
	AST_LIT8: assert property (@(posedge clock) disable iff (sys_rst)
		(exec && opc == citd_pkg::OP_MOV_LIT8) |-> rf.wd[7:0] == lit8)
		else $error("byte literal not loaded");
	AST_STORE_ADDR: assert property (@(posedge clock) disable iff (sys_rst)
		(exec && opc == citd_pkg::OP_STORE_IDX) |-> data_we && data_addr == 16'(rf.db + off16))
		else $error("indexed store address wrong");
	AST_TWO_WORD: assert property (@(posedge clock) disable iff (sys_rst)
		(exec && opc == citd_pkg::OP_JUMP) |=> state_r == citd_pkg::CITD_SECOND ##1 state_r == citd_pkg::CITD_FETCH)
		else $error("jump did not take second word");
	AST_FILE_WB: assert property (@(posedge clock) disable iff (sys_rst)
		(exec && opc == citd_pkg::OP_MOV_FILE && !use_def) |-> data_we && data_wdata == data_rdata)
		else $error("file register not written back");
	AST_DEF_DEST: assert property (@(posedge clock) disable iff (sys_rst)
		(exec && opc == citd_pkg::OP_MOV_FILE) |-> rf.we == use_def)
		else $error("default destination misrouted");
	AST_RPT_LOAD: assert property (@(posedge clock) disable iff (sys_rst)
		(exec && opc == citd_pkg::OP_REPEAT) |=> rpt_r == citd_pkg::DIV_REPEAT_CNT)
		else $error("repeat count not loaded");
endmodule

// File: verilog/citd_cycle_cnt.sv
// Cycle counter that stalls fetch for multi-cycle instructions.
// Assumes load is only asserted when idle.
`timescale 1ns/100ps
module citd_cycle_cnt (
	input wire logic clock, // Clock
	input wire logic sys_rst, // Sync reset
	input wire logic load, // Start a count
	input wire logic [2:0] cycles, // Total cycles
	output logic busy // Extra cycles pending
);
	logic [2:0] cnt_r;
	assign busy = cnt_r != 3'h0;
	always_ff @(posedge clock) begin
		if (sys_rst) cnt_r <= 3'h0;
		else if (load) cnt_r <= cycles - 3'h1;
		else if (busy) cnt_r <= cnt_r - 3'h1;
	end
endmodule

// File: verilog/citd_regbank.sv
// Sixteen working registers with two read ports and a pair write.
// Assumes writes are taken on the rising clock edge.
`timescale 1ns/100ps
module citd_regbank (
	input wire logic clock, // Clock
	input wire logic sys_rst, // Sync reset
	citd_rf_if.bank rf // Register access
);
	logic [15:0] regs_r [16];
	assign rf.da = regs_r[rf.ra];
	assign rf.db = regs_r[rf.rb];
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			for (int i = 0; i < 16; i++) regs_r[i] <= 16'h0000;
		end else begin
			if (rf.we) regs_r[rf.wa] <= rf.wd;
			// Pair fills the next-numbered register
			if (rf.we2) regs_r[4'(rf.wa + 4'h1)] <= rf.wd2;
		end
	end
endmodule
